// >>> logic/opfetch_pkg.sv
package opfetch_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int          WORD_W       = 16;
    localparam int          UPC_W        = 8;
    localparam int          REG_ADDR_W   = 5;
    localparam int          STAT_W       = 3;
    typedef logic [WORD_W-1:0] word_t;
    typedef logic [UPC_W-1:0]  upc_t;

    // ----------------------------------------
    // Control-store locations
    // ----------------------------------------
    localparam upc_t        LOC_ENTRY    = 8'h01;
    localparam upc_t        BR_SRC_MODE2 = 8'h84;
    localparam upc_t        LOC_S21      = 8'h85;
    localparam upc_t        LOC_S22      = 8'hc1;
    localparam upc_t        LOC_S23      = 8'h0c;
    localparam upc_t        LOC_S12      = 8'ha4;
    localparam upc_t        LOC_S02      = 8'h07;
    localparam upc_t        BR_DST_MODE6 = 8'h4c;
    localparam upc_t        LOC_D61      = 8'h4d;
    localparam upc_t        LOC_D62      = 8'h3d;
    localparam upc_t        LOC_D63      = 8'h3f;

    // ----------------------------------------
    // Datapath constants
    // ----------------------------------------
    localparam logic [2:0]  PC_INDEX     = 3'h7;
    localparam logic [2:0]  DST_MODE_IDX = 3'h6;
    localparam word_t       WORD_STEP    = 16'h0002;
    localparam word_t       B_CONST_ONE  = 16'h0001;
    localparam word_t       WORD_ZERO    = 16'h0000;

    // ----------------------------------------
    // Register map (word index) and fields
    // ----------------------------------------
    localparam logic [4:0]  REG_CTRL     = 5'h00;
    localparam logic [4:0]  REG_INSTR    = 5'h01;
    localparam logic [4:0]  REG_STATUS   = 5'h02;
    localparam logic [4:0]  REG_MASK     = 5'h03;
    localparam logic [4:0]  REG_BREG     = 5'h04;
    localparam logic [4:0]  REG_SCRATCH  = 5'h05;
    localparam logic [4:0]  REG_UPC      = 5'h06;
    localparam logic [4:0]  REG_OPADDR   = 5'h07;
    localparam logic [4:0]  REG_GPR_BASE = 5'h08;
    localparam int          CTRL_START   = 0;
    localparam int          ST_DONE      = 0;
    localparam int          ST_ODD_ERR   = 1;
    localparam int          ST_UNSUPP    = 2;
    localparam logic [STAT_W-1:0] STAT_RESET = 3'h0;
endpackage : opfetch_pkg

// >>> logic/operand_fetch_microsequencer.sv
// Behaviour
// - At 205 load the bus address from the source register given by instruction bits 8:6, start a read and go to 301.
// - With the program counter as source, autoincrement fetches the word after the instruction as an immediate.
// - The allow-odd-byte control is sent high with every source read; an odd source address on a word instruction is refused before any read.
// - An odd bus address without allow-odd-byte is a bus error.
// - At 301 form the incremented source pointer: plus one for byte, plus two for word instructions.
// - The increment is source on A, carry-in on, and a +1 constant on B only for non-byte instructions, A plus B.
// - At 014 hold until the source read completes, then write the incremented value back and go to 244.
// - At 244 capture the returned data into B and, for non-byte instructions, go to 007.
// - At 007 copy the source operand into scratch register 10.
// - The destination branch uses instruction bits 5:3 and for mode 6 ORs 114 into a next field of 1, giving 115.
// - For destination mode 6 on the program counter the operand address is index word plus updated counter.
// - At 115 load the bus address from the program counter, read the index word and go to 075.
// - At 075 load B with the program counter plus two and go to 077.
// - The clock-hold control stops the next microstep until the pending bus transfer has completed.
// - The next address is the next-address field ORed with recognised branch bits, unchanged when there are none.
module operand_fetch_microsequencer (
    input  wire logic                          clock,
    input  wire logic                          arst_n,
    input  wire logic                          clockEnable,
    input  wire logic [opfetch_pkg::REG_ADDR_W-1:0] regAddr,
    input  wire opfetch_pkg::word_t            regWrData,
    input  wire logic                          regWrStrobe,
    input  wire logic                          regRdStrobe,
    output opfetch_pkg::word_t                 regRdData,
    output logic                               irq,
    output logic                               busReadReq,
    output opfetch_pkg::word_t                 busAddr,
    output logic                               busAllowOdd,
    input  wire logic                          busAck,
    input  wire opfetch_pkg::word_t            busRdData
);
    import opfetch_pkg::*;

    typedef enum logic {IDLE, RUN} seq_state_e;

    // ----------------------------------------
    // Next-address field of each microword
    // ----------------------------------------
    function automatic upc_t next_address_field(input upc_t loc);
        unique case (loc)
            LOC_S21: next_address_field = LOC_S22;
            LOC_S22: next_address_field = LOC_S23;
            LOC_S23: next_address_field = LOC_S12;
            LOC_S12: next_address_field = LOC_S02;
            LOC_S02: next_address_field = LOC_ENTRY;
            LOC_D61: next_address_field = LOC_D62;
            LOC_D62: next_address_field = LOC_D63;
            default: next_address_field = LOC_ENTRY;
        endcase
    endfunction

    function automatic logic is_byte_instr(input word_t instr);
        is_byte_instr = instr[15] && (instr[14:12] != 3'h0) && (instr[14:12] != 3'h7);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    seq_state_e             state_ff;
    upc_t                   upc_ff;
    word_t                  instr_ff;
    word_t                  bReg_ff;
    word_t                  scratch_ff;
    word_t                  busData_ff;
    word_t                  opAddr_ff;
    word_t                  gpr_ff [8];
    word_t                  busAddr_ff;
    logic                   busReq_ff;
    logic                   allowOdd_ff;
    logic [STAT_W-1:0]      status_ff;
    logic [STAT_W-1:0]      mask_ff;
    word_t                  rdData_ff;

    logic [2:0]             srcSel;
    logic [2:0]             dstMode;
    logic                   byteInstr;
    word_t                  srcValue;
    word_t                  pcValue;
    word_t                  aluSum;
    upc_t                   branchBits;
    upc_t                   nxt_upc;
    logic                   holdStep;
    logic                   startsRead;
    logic                   oddBad;
    logic                   step;
    logic                   startCmd;
    logic [STAT_W-1:0]      statSet;

    assign srcSel    = instr_ff[8:6];
    assign dstMode   = instr_ff[5:3];
    assign byteInstr = is_byte_instr(instr_ff);
    assign srcValue  = gpr_ff[srcSel];
    assign pcValue   = gpr_ff[PC_INDEX];
    assign startCmd  = regWrStrobe && (regAddr == REG_CTRL) && regWrData[CTRL_START];

    // ----------------------------------------
    // ALU and microbranch
    // ----------------------------------------
    // A = source, B = +1 only for word ops, carry in always on
    assign aluSum = srcValue + (byteInstr ? WORD_ZERO : B_CONST_ONE) + B_CONST_ONE;

    always_comb begin
        branchBits = '0;
        if (upc_ff == LOC_S02 && dstMode == DST_MODE_IDX) begin
            branchBits = BR_DST_MODE6;
        end
    end

    assign nxt_upc = next_address_field(upc_ff) | branchBits;

    assign startsRead = (upc_ff == LOC_S21) || (upc_ff == LOC_D61);
    assign oddBad = (upc_ff == LOC_S21) ? (srcValue[0] && !byteInstr)
                                        : pcValue[0];

    // Hold on pending reads; a new read waits for the last acknowledge to drop
    assign holdStep = (((upc_ff == LOC_S23) || (upc_ff == LOC_D63)) && busReq_ff)
                   || (startsRead && (busReq_ff || busAck));
    assign step = clockEnable && (state_ff == RUN) && !holdStep;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= IDLE;
            upc_ff   <= LOC_ENTRY;
        end else if (clockEnable) begin
            if (state_ff == IDLE) begin
                if (startCmd) begin
                    state_ff <= RUN;
                    upc_ff   <= LOC_ENTRY | BR_SRC_MODE2;
                end
            end else if (step) begin
                unique case (upc_ff)
                    LOC_S21, LOC_D61: begin
                        if (oddBad) begin
                            state_ff <= IDLE;
                        end else begin
                            upc_ff <= nxt_upc;
                        end
                    end
                    LOC_S12: begin
                        if (byteInstr) begin
                            state_ff <= IDLE;
                        end else begin
                            upc_ff <= nxt_upc;
                        end
                    end
                    LOC_S02: begin
                        upc_ff <= nxt_upc;
                        if (nxt_upc == LOC_ENTRY) begin
                            state_ff <= IDLE;
                        end
                    end
                    LOC_D63: state_ff <= IDLE;
                    default: upc_ff <= nxt_upc;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Datapath registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bReg_ff    <= WORD_ZERO;
            scratch_ff <= WORD_ZERO;
            opAddr_ff  <= WORD_ZERO;
        end else if (step) begin
            unique case (upc_ff)
                LOC_S22: bReg_ff    <= aluSum;
                LOC_S12: bReg_ff    <= busData_ff;
                LOC_S02: scratch_ff <= bReg_ff;
                LOC_D62: bReg_ff    <= pcValue + WORD_STEP;
                LOC_D63: opAddr_ff  <= busData_ff + bReg_ff;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            instr_ff <= WORD_ZERO;
            for (int i = 0; i < 8; i++) begin
                gpr_ff[i] <= WORD_ZERO;
            end
        end else if (clockEnable) begin
            if (step && upc_ff == LOC_S23) begin
                gpr_ff[srcSel] <= bReg_ff;
            end else if (step && upc_ff == LOC_D63) begin
                gpr_ff[PC_INDEX] <= bReg_ff;
            end else if (regWrStrobe && state_ff == IDLE
                         && regAddr[4:3] == REG_GPR_BASE[4:3]) begin
                gpr_ff[regAddr[2:0]] <= regWrData;
            end
            if (regWrStrobe && state_ff == IDLE && regAddr == REG_INSTR) begin
                instr_ff <= regWrData;
            end
        end
    end

    // ----------------------------------------
    // Bus read master
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busReq_ff   <= 1'b0;
            busAddr_ff  <= WORD_ZERO;
            allowOdd_ff <= 1'b0;
            busData_ff  <= WORD_ZERO;
        end else if (clockEnable) begin
            if (busReq_ff && busAck) begin
                busReq_ff  <= 1'b0;
                busData_ff <= busRdData;
            end else if (step && startsRead && !oddBad) begin
                busReq_ff   <= 1'b1;
                busAddr_ff  <= (upc_ff == LOC_S21) ? srcValue : pcValue;
                allowOdd_ff <= (upc_ff == LOC_S21);
            end
        end
    end

    assign busReadReq  = busReq_ff;
    assign busAddr     = busAddr_ff;
    assign busAllowOdd = allowOdd_ff;

    // ----------------------------------------
    // Status, mask and interrupt
    // ----------------------------------------
    always_comb begin
        statSet = '0;
        if (step) begin
            statSet[ST_DONE]    = (upc_ff == LOC_D63);
            statSet[ST_ODD_ERR] = startsRead && oddBad;
            statSet[ST_UNSUPP]  = ((upc_ff == LOC_S12) && byteInstr)
                               || ((upc_ff == LOC_S02) && (nxt_upc == LOC_ENTRY));
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            status_ff <= STAT_RESET;
            mask_ff   <= STAT_RESET;
        end else if (clockEnable) begin
            // A new event wins over a write-one clear in the same cycle
            if (regWrStrobe && regAddr == REG_STATUS) begin
                status_ff <= (status_ff & ~regWrData[STAT_W-1:0]) | statSet;
            end else begin
                status_ff <= status_ff | statSet;
            end
            if (regWrStrobe && regAddr == REG_MASK) begin
                mask_ff <= regWrData[STAT_W-1:0];
            end
        end
    end

    assign irq = |(status_ff & mask_ff);

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdData_ff <= WORD_ZERO;
        end else if (clockEnable) begin
            if (regRdStrobe) begin
                unique case (regAddr)
                    REG_CTRL:    rdData_ff <= {15'h0000, state_ff == RUN};
                    REG_INSTR:   rdData_ff <= instr_ff;
                    REG_STATUS:  rdData_ff <= {13'h0000, status_ff};
                    REG_MASK:    rdData_ff <= {13'h0000, mask_ff};
                    REG_BREG:    rdData_ff <= bReg_ff;
                    REG_SCRATCH: rdData_ff <= scratch_ff;
                    REG_UPC:     rdData_ff <= {8'h00, upc_ff};
                    REG_OPADDR:  rdData_ff <= opAddr_ff;
                    default:     rdData_ff <= gpr_ff[regAddr[2:0]];
                endcase
            end else begin
                rdData_ff <= WORD_ZERO;
            end
        end
    end

    assign regRdData = rdData_ff;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_src_start;
        step && upc_ff == LOC_S21 && !oddBad;
    endsequence

    sequence s_read_issued(word_t addr);
        busReq_ff && busAddr_ff == addr;
    endsequence

    a_src_read_go: assert property (
        s_src_start |=> s_read_issued($past(srcValue)) and (upc_ff == LOC_S22))
        else $error("source read not started at 205");

    a_imm_from_pc: assert property (
        (s_src_start and (srcSel == PC_INDEX)) |=> busAddr_ff == $past(pcValue)
        ##1 !step || gpr_ff[PC_INDEX] == $past(pcValue, 2))
        else $error("immediate fetch not from program counter");

    a_odd_allow: assert property (
        step && upc_ff == LOC_S21 && srcValue[0] && byteInstr |=> busReq_ff && busAllowOdd)
        else $error("odd byte read refused");

    a_odd_error: assert property (
        step && startsRead && oddBad |=> status_ff[ST_ODD_ERR] && !busReq_ff && state_ff == IDLE)
        else $error("odd address not flagged as bus error");

    a_inc_amount: assert property (
        step && upc_ff == LOC_S22 |=>
        bReg_ff == $past(srcValue) + (byteInstr ? 16'h0001 : 16'h0002))
        else $error("autoincrement amount wrong");

    a_hold_stall: assert property (
        clockEnable && upc_ff == LOC_S23 && busReq_ff && state_ff == RUN |=>
        upc_ff == LOC_S23)
        else $error("microstep advanced during pending read");

    a_hold_release: assert property (
        clockEnable && state_ff == RUN && upc_ff == LOC_S23 && !busReq_ff |=>
        upc_ff == LOC_S12 && gpr_ff[$past(srcSel)] == $past(bReg_ff))
        else $error("writeback or advance to 244 missing");

    a_data_capture: assert property (
        step && upc_ff == LOC_S12 && !byteInstr |=> bReg_ff == $past(busData_ff)
        && upc_ff == LOC_S02)
        else $error("bus data not captured at 244");

    a_scratch_copy: assert property (
        step && upc_ff == LOC_S02 |=> scratch_ff == $past(bReg_ff))
        else $error("scratch copy missing");

    a_dest_branch: assert property (
        step && upc_ff == LOC_S02 && dstMode == DST_MODE_IDX |=> upc_ff == LOC_D61)
        else $error("destination branch not taken");

    a_index_read: assert property (
        step && upc_ff == LOC_D61 && !oddBad |=> s_read_issued($past(pcValue))
        and (!busAllowOdd && upc_ff == LOC_D62))
        else $error("index word read not started");

    a_pc_plus_two: assert property (
        step && upc_ff == LOC_D62 |=> bReg_ff == $past(pcValue) + 16'h0002
        && upc_ff == LOC_D63)
        else $error("program counter plus two not formed");

    a_index_addr: assert property (
        step && upc_ff == LOC_D63 |=> opAddr_ff == $past(busData_ff) + $past(bReg_ff))
        else $error("indexed operand address wrong");

endmodule : operand_fetch_microsequencer

// >>> test/bus_memory_model.sv
module bus_memory_model (
    input  wire logic               clock,
    input  wire logic               arst_n,
    input  wire logic               busReadReq,
    input  wire opfetch_pkg::word_t busAddr,
    input  wire logic               busAllowOdd,
    output logic                    busAck,
    output opfetch_pkg::word_t      busRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    import opfetch_pkg::*;

    word_t mem [word_t];
    int    delay = 0;
    int    waitCnt;
    word_t seenAddr [$];
    logic  seenOdd [$];

    // ----------------------------------------
    // Interlocked read slave
    // ----------------------------------------
    // Data toggle while idle so a stale word is never mistaken for an answer
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busAck    <= 1'b0;
            busRdData <= 16'h0000;
            waitCnt   <= 0;
        end else if (busReadReq && !busAck) begin
            if (waitCnt == 0) begin
                seenAddr.push_back(busAddr);
                seenOdd.push_back(busAllowOdd);
            end
            if (waitCnt >= delay) begin
                busAck    <= 1'b1;
                busRdData <= mem.exists(busAddr) ? mem[busAddr] : 16'hdead;
                waitCnt   <= 0;
            end else begin
                waitCnt <= waitCnt + 1;
            end
        end else if (!busReadReq) begin
            busAck    <= 1'b0;
            busRdData <= ~busRdData;
        end
    end
endmodule // bus_memory_model

// >>> test/operand_fetch_microsequencer_tb.sv
module operand_fetch_microsequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import opfetch_pkg::*;

    logic       clock = 1'b0;
    logic       arst_n = 1'b0;
    logic       clockEnable = 1'b1;
    logic [4:0] regAddr = 5'h00;
    word_t      regWrData = 16'h0000;
    logic       regWrStrobe = 1'b0;
    logic       regRdStrobe = 1'b0;
    word_t      regRdData;
    logic       irq;
    logic       busReadReq;
    word_t      busAddr;
    logic       busAllowOdd;
    logic       busAck;
    word_t      busRdData;
    int         fails = 0;
    int         total_checks = 0;
    int         cycles = 0;

    operand_fetch_microsequencer uut (
        .clock(clock), .arst_n(arst_n), .clockEnable(clockEnable), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
        .regRdData(regRdData), .irq(irq), .busReadReq(busReadReq), .busAddr(busAddr),
        .busAllowOdd(busAllowOdd), .busAck(busAck), .busRdData(busRdData)
    );

    bus_memory_model mem0 (
        .clock(clock), .arst_n(arst_n), .busReadReq(busReadReq), .busAddr(busAddr),
        .busAllowOdd(busAllowOdd), .busAck(busAck), .busRdData(busRdData)
    );

    initial begin
        forever #2 clock = ~clock;
    end

    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input word_t got, input word_t exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkbit(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic wr(input logic [4:0] a, input word_t d);
        @(posedge clock);
        regAddr     <= a;
        regWrData   <= d;
        regWrStrobe <= 1'b1;
        @(posedge clock);
        regWrStrobe <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output word_t d);
        @(posedge clock);
        regAddr     <= a;
        regRdStrobe <= 1'b1;
        @(posedge clock);
        regRdStrobe <= 1'b0;
        #1 d = regRdData;
    endtask

    task automatic chkreg(input logic [4:0] a, input word_t exp);
        word_t d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic chkbus(input int i, input word_t a, input logic odd);
        chk(mem0.seenAddr[i], a);
        chkbit(mem0.seenOdd[i], odd);
    endtask

    // Start one instruction and poll the running flag; a slow run also freezes the clock enable
    task automatic go(input word_t ins, input int dly);
        word_t d;
        mem0.delay = dly;
        mem0.seenAddr.delete();
        mem0.seenOdd.delete();
        wr(REG_INSTR, ins);
        wr(REG_CTRL, 16'h0001);
        if (dly > 0) begin
            repeat (3) @(posedge clock);
            clockEnable <= 1'b0;
            repeat (4) @(posedge clock);
            clockEnable <= 1'b1;
        end
        for (int i = 0; i < 200; i++) begin
            rd(REG_CTRL, d);
            if (d[0] === 1'b0) break;
        end
        chk(d, 16'h0000);
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        chkreg(REG_STATUS, 16'h0000);
        chkreg(REG_CTRL, 16'h0000);
        chkreg(REG_UPC, 16'h0001);
        chkbit(irq, 1'b0);
        chkbit(busReadReq, 1'b0);
        wr(REG_GPR_BASE + 5'h04, 16'h0abc);
        wr(5'h14, 16'h5555);
        chkreg(5'h14, 16'h0abc);

        // Immediate source on the counter, indexed destination on the counter
        mem0.mem[16'h0202] = 16'h000d;
        mem0.mem[16'h0204] = 16'h0040;
        wr(REG_GPR_BASE + 5'h07, 16'h0202);
        go(16'h25f7, 0);
        chkbus(0, 16'h0202, 1'b1);
        chkbus(1, 16'h0204, 1'b0);
        chkreg(REG_SCRATCH, 16'h000d);
        chkreg(REG_GPR_BASE + 5'h07, 16'h0206);
        chkreg(REG_OPADDR, 16'h0246);
        chkreg(REG_STATUS, 16'h0001);
        wr(REG_STATUS, 16'h0007);
        chkreg(REG_STATUS, 16'h0000);

        // Register source with a slow slave and a frozen clock enable
        mem0.mem[16'h0300] = 16'h1234;
        mem0.mem[16'h0400] = 16'h0010;
        wr(REG_GPR_BASE + 5'h03, 16'h0300);
        wr(REG_GPR_BASE + 5'h07, 16'h0400);
        go(16'h14f7, 7);
        chkbus(0, 16'h0300, 1'b1);
        chkbus(1, 16'h0400, 1'b0);
        chkreg(REG_GPR_BASE + 5'h03, 16'h0302);
        chkreg(REG_SCRATCH, 16'h1234);
        chkreg(REG_OPADDR, 16'h0412);
        chkreg(REG_GPR_BASE + 5'h07, 16'h0402);
        wr(REG_STATUS, 16'h0007);

        // Odd address on a word instruction, with the interrupt path
        wr(REG_MASK, 16'h0002);
        wr(REG_GPR_BASE + 5'h03, 16'h0301);
        go(16'h14f7, 0);
        chk(word_t'(mem0.seenAddr.size()), 16'h0000);
        chkreg(REG_STATUS, 16'h0002);
        chkreg(REG_GPR_BASE + 5'h03, 16'h0301);
        chkbit(irq, 1'b1);
        wr(REG_MASK, 16'h0000);
        #1 chkbit(irq, 1'b0);
        wr(REG_MASK, 16'h0002);
        #1 chkbit(irq, 1'b1);
        wr(REG_STATUS, 16'h0002);
        #1 chkbit(irq, 1'b0);
        wr(REG_MASK, 16'h0000);

        // Byte instruction at an odd address
        mem0.mem[16'h0301] = 16'h00aa;
        go(16'h94f7, 0);
        chkbus(0, 16'h0301, 1'b1);
        chkreg(REG_GPR_BASE + 5'h03, 16'h0302);
        chkreg(REG_STATUS, 16'h0004);
        wr(REG_STATUS, 16'h0007);

        // Destination mode other than indexed
        wr(REG_GPR_BASE + 5'h03, 16'h0300);
        go(16'h14d2, 0);
        chk(word_t'(mem0.seenAddr.size()), 16'h0001);
        chkreg(REG_SCRATCH, 16'h1234);
        chkreg(REG_GPR_BASE + 5'h03, 16'h0302);
        chkreg(REG_STATUS, 16'h0004);
        complete_run();
    end
endmodule // operand_fetch_microsequencer_tb
